// file: sccc_consts.vh
// constants for the smart card character control block
`ifndef SCCC_CONSTS_VH
`define SCCC_CONSTS_VH
// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define SCCC_IDX_EXT_DIV 16'hFE10
`define SCCC_IDX_PARITY 16'hFE11
`define SCCC_IDX_CHAR 16'hFE12
`define SCCC_IDX_PROTO 16'hFE20
`define SCCC_IDX_HALF_ETU 16'hFE21
`define SCCC_IDX_STATUS 16'hFE22
`define SCCC_ADDR_W 18
// ------------------------------------------------------------
// reset values and writable masks
// ------------------------------------------------------------
`define SCCC_RST_EXT_DIV 6'h0C
`define SCCC_RST_PARITY 7'h00
`define SCCC_RST_CHAR 8'h2C
`define SCCC_MASK_CHAR 8'h7C
`define SCCC_RST_HALF_ETU 16'h0174
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define SCCC_PAR_CHECK_DIS 6
`define SCCC_PAR_BREAK_GENERATE_DISABLE_DIS 5
`define SCCC_PAR_BREAK_DETECT_DISABLE_DIS 4
`define SCCC_PAR_REPEAT 3
`define SCCC_PAR_DROP 2
`define SCCC_PAR_INJECT 1
`define SCCC_PAR_FORCE 0
`define SCCC_CHR_EXPECT_TS 6
`define SCCC_CHR_DIRECT 5
`define SCCC_CHR_BRK_HI 4
`define SCCC_CHR_BRK_LO 3
// ------------------------------------------------------------
// character timeline in half-ETU steps, then the direct ts pattern and the divider minimum
// ------------------------------------------------------------
`define SCCC_H_PARITY_SMP 6'd19
`define SCCC_H_RX_DONE 6'd20
`define SCCC_H_BRK_START 6'd21
`define SCCC_H_BRK_SMP 6'd22
`define SCCC_H_TX_END 6'd24
`define SCCC_H_TX_BITS 6'd20
`define SCCC_H_DATA_FIRST 6'd3
`define SCCC_H_BRK_LEN_1 6'd2
`define SCCC_H_BRK_LEN_15 6'd3
`define SCCC_H_BRK_LEN_2 6'd4
`define SCCC_TS_DIRECT 8'h3B
`define SCCC_DIV_MIN 6'h01
`endif

// file: sccc_char_ctrl.v
// smart card character control: card clock divider, t=0 parity/break, ts detection
//
// Added by the designer: the APB slave port.
`include "sccc_consts.vh"

module sccc_char_ctrl (
	input wire CLK_I,
	input wire RSTN_I,
	input wire PSEL_I,
	input wire PENABLE_I,
	input wire PWRITE_I,
	input wire [`SCCC_ADDR_W-1:0] PADDR_I,
	input wire [31:0] PWDATA_I,
	output reg [31:0] PRDATA_O,
	output reg PREADY_O,
	output reg PSLVERR_O,
	input wire IO_I,
	output reg IO_O,
	output reg IO_OE_O,
	output reg SCLK_O,
	input wire TX_VALID_I,
	input wire [7:0] TX_DATA_I,
	output reg TX_READY_O,
	output reg RX_VALID_O,
	output reg [7:0] RX_DATA_O,
	output reg RX_PERR_O
);

	localparam [1:0] ST_IDLE = 2'b00;
	localparam [1:0] ST_RX = 2'b01;
	localparam [1:0] ST_TX = 2'b10;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	reg [5:0] ext_div;
	reg [6:0] par_ctl;
	reg [7:0] chr_ctl;
	reg proto_t1;
	reg [15:0] half_etu;
	reg stat_perr;
	reg stat_brk;

	// line engine state
	reg [1:0] state;
	reg [5:0] div_cnt;
	reg tick;
	reg [15:0] tick_cnt;
	reg [5:0] half;
	reg [8:0] rx_sh;
	reg [9:0] tx_frame;
	reg io_prev;
	reg rx_bad;
	reg brk_on;
	reg brk_seen;
	reg [5:0] brk_end;

	// word index and the completing edge of an access
	wire [15:0] idx = PADDR_I[`SCCC_ADDR_W-1:2];
	wire apb_go = PSEL_I && PENABLE_I && PREADY_O;
	wire wr_go = apb_go && PWRITE_I;
	wire is_t0 = ~proto_t1;
	wire direct = chr_ctl[`SCCC_CHR_DIRECT];
	// one pulse per half etu, counted in divider ticks
	wire half_step = tick && (tick_cnt >= half_etu - 16'h0001);
	// number of the half step that the next half_step pulse completes
	wire [5:0] half_nx = half + 6'h01;
	// mid-bit sample points: odd half steps from the first data bit to parity
	wire rx_smp = half_nx[0] && (half_nx >= `SCCC_H_DATA_FIRST) &&
		(half_nx <= `SCCC_H_PARITY_SMP);
	wire [1:0] brk_sel = chr_ctl[`SCCC_CHR_BRK_HI:`SCCC_CHR_BRK_LO];
	wire [5:0] div_eff = (ext_div == 6'h00) ? `SCCC_DIV_MIN : ext_div;

	// ------------------------------------------------------------
	// convention helpers
	// ------------------------------------------------------------
	// inverse convention: line level inverted and most significant bit first
	function [7:0] conv;
		input [7:0] d;
		input dir;
		integer i;
		begin
			for (i = 0; i < 8; i = i + 1) begin
				conv[i] = dir ? d[i] : ~d[7-i];
			end
		end
	endfunction

	// raw pattern of a direct-convention ts, as the line is sampled
	wire ts_direct = (rx_sh[7:0] == `SCCC_TS_DIRECT);
	// a pending ts is decoded in the convention it announces, not the old one
	wire rx_dir = chr_ctl[`SCCC_CHR_EXPECT_TS] ? ts_direct : direct;

	// logical value of the received character and its parity bit
	wire [7:0] rx_data = conv(rx_sh[7:0], rx_dir);
	wire rx_par = rx_dir ? rx_sh[8] : ~rx_sh[8];
	wire par_dis = par_ctl[`SCCC_PAR_CHECK_DIS];
	wire rx_perr = ~par_dis &&
		((^{rx_data, rx_par}) || par_ctl[`SCCC_PAR_FORCE]);

	// break length in half-ETU steps; the reserved code acts like two etu
	reg [5:0] brk_len;
	always @* begin
		case (brk_sel)
			2'b00: brk_len = `SCCC_H_BRK_LEN_1;
			2'b01: brk_len = `SCCC_H_BRK_LEN_15;
			default: brk_len = `SCCC_H_BRK_LEN_2;
		endcase
	end

	// ------------------------------------------------------------
	// apb slave: one wait state, decode by word index
	// ------------------------------------------------------------
	reg [31:0] rd_mux;
	reg rd_hit;
	always @* begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		case (idx)
			`SCCC_IDX_EXT_DIV: rd_mux = {26'h0, ext_div};
			`SCCC_IDX_PARITY: rd_mux = {25'h0, par_ctl};
			`SCCC_IDX_CHAR: rd_mux = {24'h0, chr_ctl};
			`SCCC_IDX_PROTO: rd_mux = {31'h0, proto_t1};
			`SCCC_IDX_HALF_ETU: rd_mux = {16'h0, half_etu};
			`SCCC_IDX_STATUS: rd_mux = {29'h0, (state != ST_IDLE), stat_brk, stat_perr};
			default: rd_hit = 1'b0;
		endcase
	end

	// answer is raised once per access phase and dropped after the completing edge
	always @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			PREADY_O <= 1'b0;
			PSLVERR_O <= 1'b0;
			PRDATA_O <= 32'h0000_0000;
		end else if (PSEL_I && PENABLE_I && !PREADY_O) begin
			PREADY_O <= 1'b1;
			PSLVERR_O <= ~rd_hit;
			PRDATA_O <= PWRITE_I ? 32'h0000_0000 : rd_mux;
		end else begin
			PREADY_O <= 1'b0;
			PSLVERR_O <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// software-written configuration
	// ------------------------------------------------------------
	always @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			ext_div <= `SCCC_RST_EXT_DIV;
			par_ctl <= `SCCC_RST_PARITY;
			proto_t1 <= 1'b0;
			half_etu <= `SCCC_RST_HALF_ETU;
		end else if (wr_go) begin
			case (idx)
				`SCCC_IDX_EXT_DIV: ext_div <= PWDATA_I[5:0];
				`SCCC_IDX_PARITY: par_ctl <= PWDATA_I[6:0];
				`SCCC_IDX_PROTO: proto_t1 <= PWDATA_I[0];
				`SCCC_IDX_HALF_ETU: half_etu <= PWDATA_I[15:0];
				// unmapped or read-only index: nothing changes
				default: ext_div <= ext_div;
			endcase
		end
	end

	// character control: hardware ts result wins over a same-cycle write
	always @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			chr_ctl <= `SCCC_RST_CHAR;
		end else begin
			if (wr_go && idx == `SCCC_IDX_CHAR) begin
				chr_ctl <= PWDATA_I[7:0] & `SCCC_MASK_CHAR;
			end
			// decide once all nine bits are shifted in, so rx_sh holds the ts itself
			if (state == ST_RX && half_step && half_nx == `SCCC_H_RX_DONE &&
				chr_ctl[`SCCC_CHR_EXPECT_TS]) begin
				chr_ctl[`SCCC_CHR_EXPECT_TS] <= 1'b0;
				chr_ctl[`SCCC_CHR_DIRECT] <= ts_direct;
			end
		end
	end

	// ------------------------------------------------------------
	// card clock divider
	// ------------------------------------------------------------
	// reload only at terminal count so a new value never shortens a phase
	always @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			div_cnt <= 6'h00;
			tick <= 1'b0;
			SCLK_O <= 1'b0;
		end else if (div_cnt == 6'h00) begin
			div_cnt <= div_eff;
			tick <= 1'b1;
			SCLK_O <= ~SCLK_O;
		end else begin
			div_cnt <= div_cnt - 6'h01;
			tick <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// character engine (half duplex: receive or transmit)
	// ------------------------------------------------------------
	always @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			state <= ST_IDLE;
			tick_cnt <= 16'h0000;
			half <= 6'h00;
			rx_sh <= 9'h000;
			tx_frame <= 10'h3FF;
			io_prev <= 1'b1;
			rx_bad <= 1'b0;
			brk_on <= 1'b0;
			brk_seen <= 1'b0;
			brk_end <= 6'h00;
			stat_perr <= 1'b0;
			stat_brk <= 1'b0;
			IO_O <= 1'b1;
			IO_OE_O <= 1'b0;
			TX_READY_O <= 1'b0;
			RX_VALID_O <= 1'b0;
			RX_DATA_O <= 8'h00;
			RX_PERR_O <= 1'b0;
		end else begin
			io_prev <= IO_I;
			RX_VALID_O <= 1'b0;
			if (half_step) begin
				tick_cnt <= 16'h0000;
			end else if (tick) begin
				tick_cnt <= tick_cnt + 16'h0001;
			end
			case (state)
				ST_IDLE: begin
					IO_OE_O <= 1'b0;
					IO_O <= 1'b1;
					half <= 6'h00;
					tick_cnt <= 16'h0000;
					brk_on <= 1'b0;
					brk_seen <= 1'b0;
					if (io_prev && !IO_I) begin
						// start-bit edge from the card
						state <= ST_RX;
						TX_READY_O <= 1'b0;
					end else if (TX_READY_O && TX_VALID_I) begin
						state <= ST_TX;
						TX_READY_O <= 1'b0;
						tx_frame <= {(^TX_DATA_I) ^ par_ctl[`SCCC_PAR_INJECT] ^ ~direct,
							conv(TX_DATA_I, direct), 1'b0};
					end else begin
						// offered only while the line is quiet: half duplex
						TX_READY_O <= 1'b1;
					end
				end
				ST_RX: begin
					if (half_step) begin
						half <= half + 6'h01;
						// sample mid-bit; a pulse completes step half_nx, not step half
						if (rx_smp) begin
							rx_sh <= {IO_I, rx_sh[8:1]};
						end
						// 10 etu: all nine bits are in, hand the character over
						if (half_nx == `SCCC_H_RX_DONE) begin
							rx_bad <= rx_perr;
							stat_perr <= rx_perr;
							RX_PERR_O <= rx_perr;
							RX_DATA_O <= rx_data;
							// drop only in t=0 with checking enabled
							RX_VALID_O <= ~(rx_perr && is_t0 &&
								par_ctl[`SCCC_PAR_DROP]);
						end
						// 10.5 etu: pull the line low if the character was bad
						if (half_nx == `SCCC_H_BRK_START) begin
							if (rx_bad && is_t0 && !par_ctl[`SCCC_PAR_BREAK_GENERATE_DISABLE_DIS]) begin
								brk_on <= 1'b1;
								IO_OE_O <= 1'b1;
								IO_O <= 1'b0;
								brk_end <= `SCCC_H_BRK_START + brk_len;
							end else begin
								state <= ST_IDLE;
							end
						end
						// release once the selected length has run out
						if (brk_on && half_nx == brk_end) begin
							IO_OE_O <= 1'b0;
							IO_O <= 1'b1;
							state <= ST_IDLE;
						end
					end
				end
				ST_TX: begin
					// open drain: drive only the low bits of the frame
					if (half < `SCCC_H_TX_BITS) begin
						IO_OE_O <= ~tx_frame[half[4:1]];
						IO_O <= tx_frame[half[4:1]];
					end else begin
						IO_OE_O <= 1'b0;
						IO_O <= 1'b1;
					end
					if (half_step) begin
						half <= half + 6'h01;
						// 11 etu: a card break holds the line low here
						if (half_nx == `SCCC_H_BRK_SMP && is_t0 &&
							!par_ctl[`SCCC_PAR_BREAK_DETECT_DISABLE_DIS]) begin
							brk_seen <= ~IO_I;
						end
						// frame over: a detected break in t=0 sends the same frame again when the repeat bit is set
						if (half_nx == `SCCC_H_TX_END) begin
							stat_brk <= brk_seen;
							half <= 6'h00;
							brk_seen <= 1'b0;
							if (!(brk_seen && par_ctl[`SCCC_PAR_REPEAT])) begin
								state <= ST_IDLE;
							end
						end
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

endmodule

// file: sccc_char_ctrl_sva.sv
// assertion checker for the smart card character control block
module sccc_chk (
	input wire logic CLK_I,
	input wire logic RSTN_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PREADY_O,
	input wire logic PSLVERR_O,
	input wire logic IO_I,
	input wire logic IO_O,
	input wire logic IO_OE_O,
	input wire logic SCLK_O,
	input wire logic TX_VALID_I,
	input wire logic TX_READY_O,
	input wire logic RX_VALID_O
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CLK_I);
	endclocking
	default disable iff (!RSTN_I);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	// idle start edge from the card opens a receive frame
	sequence s_rx_start;
		$fell(IO_I) && TX_READY_O && !IO_OE_O;
	endsequence
	AST_APB_ONE_WAIT: assert property (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
		else $error("apb answer late");
	AST_READY_PULSE: assert property (PREADY_O |=> !PREADY_O)
		else $error("ready held too long");
	AST_ERR_WITH_READY: assert property (PSLVERR_O |-> PREADY_O)
		else $error("error without ready");
	AST_SCLK_HOLD: assert property ($changed(SCLK_O) |=> $stable(SCLK_O))
		else $error("card clock too fast");
	AST_BRK_LOW: assert property (IO_OE_O |-> !IO_O)
		else $error("line driven high");
	AST_NO_EARLY_BRK: assert property (s_rx_start |=> !IO_OE_O [*8])
		else $error("line driven early");
	AST_TX_TAKE: assert property (TX_VALID_I && TX_READY_O |=> !TX_READY_O)
		else $error("ready after take");
	AST_RX_PULSE: assert property (RX_VALID_O |=> !RX_VALID_O)
		else $error("rx strobe held");
endmodule

bind sccc_char_ctrl sccc_chk sccc_chk_i (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .IO_I(IO_I),
	.IO_O(IO_O), .IO_OE_O(IO_OE_O), .SCLK_O(SCLK_O), .TX_VALID_I(TX_VALID_I),
	.TX_READY_O(TX_READY_O), .RX_VALID_O(RX_VALID_O));

// file: sccc_card_model.sv
// smart card model on the open-drain io line, direct levels
module sccc_card_model (
	input wire logic clk_i,
	input wire logic line_i,
	output logic drv_o
);
	timeunit 1ns;
	timeprecision 1ns;
	parameter int ETU = 8;
	int brk_left = 0;
	int rx_cnt = 0;
	logic [8:0] rx_last = '0;
	logic busy = 0;
	initial drv_o = 1'b1;
	// sends start, 8 bits lsb first, parity; then releases to the pull-up
	task automatic send(input logic [8:0] b);
		busy = 1;
		@(posedge clk_i) drv_o <= 1'b0;
		repeat (ETU) @(posedge clk_i);
		for (int i = 0; i < 9; i++) begin
			drv_o <= b[i];
			repeat (ETU) @(posedge clk_i);
		end
		drv_o <= 1'b1;
		// stay deaf past any break so it is not taken for a start bit
		repeat (3 * ETU) @(posedge clk_i);
		busy = 0;
	endtask
	// samples mid-bit; a break held 10.5..11.5 etu covers the 11 etu sample
	always begin
		@(negedge line_i);
		if (!busy) begin
			repeat (ETU + ETU / 2) @(posedge clk_i);
			for (int i = 0; i < 9; i++) begin
				rx_last[i] = line_i;
				repeat (ETU) @(posedge clk_i);
			end
			rx_cnt++;
			if (brk_left > 0) begin
				drv_o <= 1'b0;
				repeat (ETU) @(posedge clk_i);
				drv_o <= 1'b1;
				brk_left--;
			end
		end
	end
endmodule

// file: tb_top.sv
// self-checking bench for the smart card character control block
`include "sccc_consts.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK_I = 0, RSTN_I = 0, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0, TX_VALID_I = 0;
	logic [`SCCC_ADDR_W-1:0] PADDR_I = '0;
	logic [31:0] PWDATA_I = '0, PRDATA_O, d;
	logic PREADY_O, PSLVERR_O, IO_O, IO_OE_O, SCLK_O, TX_READY_O, RX_VALID_O, RX_PERR_O;
	logic er, card_drv;
	logic [7:0] TX_DATA_I = '0, RX_DATA_O;
	wire IO_I = IO_OE_O ? 1'b0 : card_drv;
	int error_cnt = 0, tests_run = 0, cyc = 0, rx_n = 0, brk_cur = 0, brk_len = 0, n;
	time t;
	int dv[3] = '{0, 2, 1};
	logic [31:0] rp[8] = '{0, 0, 0, 0, 4, 'h40, 1, 'h20};
	logic [31:0] rc[8] = '{'h2C, 'h20, 'h28, 'h30, 'h30, 'h30, 'h30, 'h30};
	logic [8:0] rb[8] = '{'h05A, 'h15A, 'h15A, 'h15A, 'h15A, 'h15A, 'h05A, 'h15A};
	logic rv[8] = '{1, 1, 1, 1, 0, 1, 1, 1};
	logic re[8] = '{0, 1, 1, 1, 1, 0, 1, 1};
	int rl[8] = '{0, 8, 12, 16, 16, 0, 16, 0};
	sccc_char_ctrl sccc_char_ctrl_i (.*);
	sccc_card_model sccc_card_model_i (.clk_i(CLK_I), .line_i(IO_I), .drv_o(card_drv));
	initial forever #10 CLK_I = ~CLK_I;
	// counts rx strobes and break lengths; cuts a hang short
	always @(posedge CLK_I) begin
		cyc++;
		if (RX_VALID_O === 1'b1) rx_n++;
		if (IO_OE_O === 1'b1) brk_cur++;
		else if (brk_cur != 0) begin
			brk_len = brk_cur;
			brk_cur = 0;
		end
		if (cyc == 30000) begin
			error_cnt++;
			stop_test();
		end
	end
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
		PSEL_I <= 1'b1;
		PWRITE_I <= w;
		PADDR_I <= {idx, 2'b00};
		PWDATA_I <= wd;
		@(posedge CLK_I);
		PENABLE_I <= 1'b1;
		do @(posedge CLK_I); while (PREADY_O !== 1'b1);
		d = PRDATA_O;
		er = PSLVERR_O;
		PSEL_I <= 1'b0;
		PENABLE_I <= 1'b0;
		@(posedge CLK_I);
	endtask
	task automatic rd(input string nm, input logic [15:0] idx, input logic [31:0] e);
		apb(1'b0, idx, '0);
		chk(nm, e, d);
	endtask
	task automatic tx(input logic [7:0] b);
		TX_DATA_I <= b;
		TX_VALID_I <= 1'b1;
		do @(posedge CLK_I); while (TX_READY_O !== 1'b1);
		TX_VALID_I <= 1'b0;
		repeat (2) @(posedge CLK_I);
		while (TX_READY_O !== 1'b1) @(posedge CLK_I);
	endtask
	task automatic rx(input logic [8:0] b, input logic v, input logic pe, input int bl);
		n = rx_n;
		brk_len = 0;
		sccc_card_model_i.send(b);
		chk("rx strobe", v, rx_n - n);
		chk("rx perr", pe, RX_PERR_O);
		chk("break len", bl, brk_len);
		if (v) chk("rx data", b[7:0], RX_DATA_O);
	endtask
	task automatic done(input string nm);
		$display("test %s finished", nm);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(posedge CLK_I);
		RSTN_I <= 1'b1;
		@(posedge CLK_I);
		rd("ext div", `SCCC_IDX_EXT_DIV, 32'h0000000C);
		rd("parity", `SCCC_IDX_PARITY, 32'h00000000);
		rd("char", `SCCC_IDX_CHAR, 32'h0000002C);
		rd("unmapped", 16'h0123, 32'h00000000);
		chk("slverr", 1'b1, er);
		done("registers");
		// period in ns is 40 per effective divider step plus 40, zero acting as one
		foreach (dv[i]) begin
			apb(1'b1, `SCCC_IDX_EXT_DIV, dv[i]);
			repeat (3) @(posedge SCLK_O);
			t = $time;
			@(posedge SCLK_O);
			chk("sclk", 40 * (dv[i] == 0 ? 1 : dv[i]) + 40, 32'($time - t));
			@(posedge CLK_I);
		end
		apb(1'b1, `SCCC_IDX_HALF_ETU, 32'h00000002);
		rd("half etu", `SCCC_IDX_HALF_ETU, 32'h00000002);
		done("clock");
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, `SCCC_IDX_PARITY, k * 2);
			tx(8'hA7);
			chk("tx frame", {^8'hA7 ^ k[0], 8'hA7}, sccc_card_model_i.rx_last);
		end
		// detection alone: the break is flagged and the character is not resent
		apb(1'b1, `SCCC_IDX_PARITY, 32'h00000000);
		sccc_card_model_i.brk_left = 1;
		n = sccc_card_model_i.rx_cnt;
		tx(8'h11);
		chk("no repeat", n + 1, sccc_card_model_i.rx_cnt);
		rd("break seen", `SCCC_IDX_STATUS, 32'h00000002);
		// with repeat the frame goes out twice; the clean resend clears the flag
		apb(1'b1, `SCCC_IDX_PARITY, 32'h00000008);
		sccc_card_model_i.brk_left = 1;
		n = sccc_card_model_i.rx_cnt;
		tx(8'h11);
		chk("repeat", n + 2, sccc_card_model_i.rx_cnt);
		rd("break cleared", `SCCC_IDX_STATUS, 32'h00000000);
		apb(1'b1, `SCCC_IDX_PROTO, 32'h00000001);
		sccc_card_model_i.brk_left = 1;
		n = sccc_card_model_i.rx_cnt;
		tx(8'h11);
		chk("t1 once", n + 1, sccc_card_model_i.rx_cnt);
		apb(1'b1, `SCCC_IDX_PROTO, 32'h00000000);
		done("transmit");
		foreach (rp[i]) begin
			apb(1'b1, `SCCC_IDX_PARITY, rp[i]);
			apb(1'b1, `SCCC_IDX_CHAR, rc[i]);
			rx(rb[i], rv[i], re[i], rl[i]);
		end
		done("receive");
		apb(1'b1, `SCCC_IDX_PARITY, 32'h00000000);
		apb(1'b1, `SCCC_IDX_CHAR, 32'h00000060);
		rx(9'h13B, 1'b1, 1'b0, 0);
		apb(1'b0, `SCCC_IDX_CHAR, '0);
		chk("ts direct", 2'b01, d[6:5]);
		apb(1'b1, `SCCC_IDX_CHAR, 32'h00000060);
		// inverse ts with its line parity bit high: logical 0x3F, even parity
		sccc_card_model_i.send(9'h103);
		chk("ts inverse data", 8'h3F, RX_DATA_O);
		chk("ts inverse perr", 1'b0, RX_PERR_O);
		apb(1'b0, `SCCC_IDX_CHAR, '0);
		chk("ts inverse", 2'b00, d[6:5]);
		// inverse convention on transmit: levels inverted, most significant bit first
		tx(8'hA7);
		chk("tx inverse", 9'h01A, sccc_card_model_i.rx_last);
		done("initial char");
		stop_test();
	end
endmodule
